// File: design/fwg_regs.svh
// Opcodes, frame counts and reset values of the write guard
`ifndef FWG_REGS_SVH
`define FWG_REGS_SVH

`define FWG_OP_WREN 8'h06
`define FWG_OP_WRDI 8'h04
`define FWG_OP_WRSR 8'h01
`define FWG_OP_PROG 8'h02
`define FWG_OP_SE4K 8'h20
`define FWG_OP_BE32 8'h52
`define FWG_OP_BE64 8'hD8
`define FWG_OP_CE_A 8'h60
`define FWG_OP_CE_B 8'hC7
`define FWG_OP_SECP 8'h42
`define FWG_OP_SECE 8'h44

`define FWG_CNT_ONE 6'h01
`define FWG_CNT_OP 6'h08
`define FWG_SEG_MAX 7'h7F
`define FWG_SEG_ZERO 7'h00
`define FWG_LATCH_RST 1'b0
`define FWG_PROT_RST 6'h00
`define FWG_COMPL_POS 5
`define FWG_WRSR_COMPL_POS 6

`endif

// File: design/fwg_pkg.sv
// Types shared by the write guard modules
package fwg_pkg;
  typedef enum logic [1:0]
  {
    FWG_IDLE = 2'b01,
    FWG_FRAME = 2'b10
  } fwg_state_t;

  typedef logic [6:0] fwg_seg_t;
endpackage

// File: design/fwg_prot_if.sv
// Carrier between frame logic and protection decoder
`timescale 1ns/1ns
interface fwg_prot_if;
  logic compl;
  logic [4:0] bp;
  fwg_pkg::fwg_seg_t rgn_first;
  fwg_pkg::fwg_seg_t rgn_last;
  logic hit;
  modport guard (output compl, bp, rgn_first, rgn_last, input hit);
  modport decode (input compl, bp, rgn_first, rgn_last, output hit);
endinterface

// File: design/fwg_prot_decode.sv
// Decodes the protect bits and checks a 4 KB segment range against them
`timescale 1ns/1ns
module fwg_prot_decode
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  fwg_prot_if.decode pif
);
  import fwg_pkg::*;
  `include "fwg_regs.svh"

  // Segments (4 KB) of one protected block for the given bits
  function automatic logic [7:0] fwg_size(input logic [4:0] bp);
    logic [7:0] n;
    n = 8'h00;
    if (!bp[4])
    begin
      case (bp[1:0])
        2'b01: n = 8'h10;
        2'b10: n = 8'h20;
        2'b11: n = 8'h40;
        default: n = 8'h00;
      endcase
    end
    else if (bp[2])
      n = 8'h08;
    else
    begin
      case (bp[1:0])
        2'b01: n = 8'h01;
        2'b10: n = 8'h02;
        2'b11: n = 8'h04;
        default: n = 8'h00;
      endcase
    end
    return n;
  endfunction

  logic all_p;
  logic none_p;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [7:0] first;
  logic [7:0] last;
  logic base_hit;
  logic in_base;

  always_comb
  begin
    first = {1'b0, pif.rgn_first};
    last = {1'b0, pif.rgn_last};
    none_p = (pif.bp[2:0] == 3'b000);
    all_p = (!pif.bp[4] && pif.bp[2]) || (pif.bp[4] && pif.bp[2:0] == 3'b111);
    if (all_p)
    begin
      lo = 8'h00;
      hi = 8'h7F;
    end
    else if (pif.bp[3])
    begin
      lo = 8'h00;
      hi = fwg_size(pif.bp) - 8'h01;
    end
    else
    begin
      lo = 8'h80 - fwg_size(pif.bp);
      hi = 8'h7F;
    end
    base_hit = !none_p && first <= hi && last >= lo;
    in_base = !none_p && first >= lo && last <= hi;
    pif.hit = pif.compl ? !in_base : base_hit;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_NONE_FREE: assert property
    (!pif.compl && pif.bp[2:0] == 3'b000 |-> !pif.hit)
    else $error("Protect bits 000 still protect");
  AST_ALL_HIT: assert property
    (!pif.compl && !pif.bp[4] && pif.bp[2] |-> pif.hit)
    else $error("All-protect setting missed a range");
  AST_TOP_EIGHTH: assert property
    (!pif.compl && pif.bp == 5'b00001
     |-> pif.hit == (pif.rgn_last >= 7'h70))
    else $error("Upper eighth decode wrong");
  AST_BOT_128TH: assert property
    (!pif.compl && pif.bp == 5'b11001
     |-> pif.hit == (pif.rgn_first == 7'h00))
    else $error("Lower 1/128 decode wrong");
  AST_COMPL_ALL: assert property
    (pif.compl && pif.bp[2:0] == 3'b000 |-> pif.hit)
    else $error("Complement of none must protect all");
  AST_COMPL_NONE: assert property
    (pif.compl && !pif.bp[4] && pif.bp[2] |-> !pif.hit)
    else $error("Complement of all must protect none");
endmodule

// File: design/fwg_guard.sv
// Write enable latch, protect bits and command gating of the flash
`timescale 1ns/1ns
// Notes on behaviour
// - Opcode 06h sets latch at frame end
// - Modifying commands need the latch set beforehand
// - Latch commands ignore whole bytes after opcode
// - Short or unaligned frame leaves latch unchanged
// - Opcode 04h clears latch at frame end
// - Protect bits change only by status write
// - Protect bits select none, a top/bottom fraction, or whole array
// - Bit3 picks top/bottom, bit4 finer granularity
// - Complement bit inverts the protected set
// - Commands touching protected bytes are ignored
// - Successful erase clears the latch
// - Low write-protect pin freezes protect bits
module fwg_guard
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic wp_n_i,
  output logic write_enable_latch_o,
  output logic protect_complement_o,
  output logic protect_bit4_granularity_o,
  output logic protect_bit3_top_bottom_o,
  output logic protect_bit2_o,
  output logic protect_bit1_o,
  output logic protect_bit0_o,
  output logic cmd_exec_o,
  output logic cmd_refused_o,
  output logic [7:0] cmd_opcode_o,
  output logic [23:0] cmd_addr_o
);
  import fwg_pkg::*;
  `include "fwg_regs.svh"

  function automatic logic fwg_is_array(input logic [7:0] op);
    return op == `FWG_OP_PROG || op == `FWG_OP_SE4K ||
      op == `FWG_OP_BE32 || op == `FWG_OP_BE64 ||
      op == `FWG_OP_CE_A || op == `FWG_OP_CE_B;
  endfunction

  function automatic logic fwg_is_erase(input logic [7:0] op);
    return op == `FWG_OP_SE4K || op == `FWG_OP_BE32 ||
      op == `FWG_OP_BE64 || op == `FWG_OP_CE_A ||
      op == `FWG_OP_CE_B || op == `FWG_OP_SECE;
  endfunction

  fwg_prot_if pif ();

  fwg_state_t state;
  fwg_state_t next_state;
  logic sck_q;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [7:0] sr;
  logic [7:0] next_sr;
  logic [7:0] op;
  logic [7:0] next_op;
  logic [7:0] data;
  logic [7:0] next_data;
  logic [23:0] addr;
  logic [23:0] next_addr;
  logic wr_latch;
  logic next_wr_latch;
  logic [5:0] prot;
  logic [5:0] next_prot;
  logic next_exec;
  logic next_refused;
  logic [7:0] next_exec_op;
  logic [23:0] next_exec_addr;
  logic sck_rise;
  logic frame_end;
  logic aligned;
  logic addr_full;
  logic [7:0] byte_in;

  // ************************************************************
  // Frame shifting and end-of-frame decision
  // ************************************************************
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_sr = sr;
    next_op = op;
    next_data = data;
    next_addr = addr;
    next_wr_latch = wr_latch;
    next_prot = prot;
    next_exec = 1'b0;
    next_refused = 1'b0;
    next_exec_op = cmd_opcode_o;
    next_exec_addr = cmd_addr_o;
    sck_rise = sck_i && !sck_q;
    frame_end = (state == FWG_FRAME) && cs_n_i;
    byte_in = {sr[6:0], mosi_i};
    aligned = (cnt[2:0] == 3'b000) && (cnt >= `FWG_CNT_OP);
    addr_full = cnt[5];
    // Region in 4 KB segments
    pif.rgn_first = addr[18:12];
    pif.rgn_last = addr[18:12];
    case (op)
      `FWG_OP_BE32:
      begin
        pif.rgn_first = {addr[18:15], 3'b000};
        pif.rgn_last = {addr[18:15], 3'b111};
      end
      `FWG_OP_BE64:
      begin
        pif.rgn_first = {addr[18:16], 4'b0000};
        pif.rgn_last = {addr[18:16], 4'b1111};
      end
      `FWG_OP_CE_A, `FWG_OP_CE_B:
      begin
        pif.rgn_first = `FWG_SEG_ZERO;
        pif.rgn_last = `FWG_SEG_MAX;
      end
      default:
      begin
        pif.rgn_first = addr[18:12];
        pif.rgn_last = addr[18:12];
      end
    endcase
    case (state)
      FWG_IDLE:
      begin
        if (!cs_n_i)
        begin
          next_state = FWG_FRAME;
          next_cnt = 6'h00;
          next_op = 8'h00;
        end
      end
      FWG_FRAME:
      begin
        if (cs_n_i)
        begin
          next_state = FWG_IDLE;
          next_exec_op = op;
          next_exec_addr = addr;
          case (op)
            `FWG_OP_WREN:
              if (aligned)
                next_wr_latch = 1'b1;
            `FWG_OP_WRDI:
              if (aligned)
                next_wr_latch = 1'b0;
            `FWG_OP_WRSR:
            begin
              if (aligned && cnt >= 6'h10 && wr_latch && wp_n_i)
              begin
                next_prot = {data[`FWG_WRSR_COMPL_POS], data[4:0]};
                next_exec = 1'b1;
                next_wr_latch = 1'b0;
              end
              else
                next_refused = 1'b1;
            end
            `FWG_OP_SECP, `FWG_OP_SECE:
            begin
              if (aligned && addr_full && wr_latch)
              begin
                next_exec = 1'b1;
                next_wr_latch = 1'b0;
              end
              else
                next_refused = 1'b1;
            end
            default:
            begin
              if (fwg_is_array(op))
              begin
                if (aligned && wr_latch && !pif.hit &&
                    (addr_full || !(op == `FWG_OP_PROG ||
                     op == `FWG_OP_SE4K || op == `FWG_OP_BE32 ||
                     op == `FWG_OP_BE64)))
                begin
                  next_exec = 1'b1;
                  next_wr_latch = 1'b0;
                end
                else
                  next_refused = 1'b1;
              end
            end
          endcase
        end
        else if (sck_rise)
        begin
          next_sr = byte_in;
          next_cnt = cnt[5] ? {1'b1, cnt[4:0] + 5'h01} : cnt + `FWG_CNT_ONE;
          if (cnt[2:0] == 3'b111)
          begin
            if (cnt == 6'h07)
              next_op = byte_in;
            if (cnt == 6'h0F)
              next_data = byte_in;
            if (cnt == 6'h0F || cnt == 6'h17 || cnt == 6'h1F)
              next_addr = {addr[15:0], byte_in};
          end
        end
      end
      default:
        next_state = FWG_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state <= FWG_IDLE;
      sck_q <= 1'b0;
      cnt <= 6'h00;
      sr <= 8'h00;
      op <= 8'h00;
      data <= 8'h00;
      addr <= 24'h00_0000;
      wr_latch <= `FWG_LATCH_RST;
      prot <= `FWG_PROT_RST;
      cmd_exec_o <= 1'b0;
      cmd_refused_o <= 1'b0;
      cmd_opcode_o <= 8'h00;
      cmd_addr_o <= 24'h00_0000;
    end
    else
    begin
      state <= next_state;
      sck_q <= sck_i;
      cnt <= next_cnt;
      sr <= next_sr;
      op <= next_op;
      data <= next_data;
      addr <= next_addr;
      wr_latch <= next_wr_latch;
      prot <= next_prot;
      cmd_exec_o <= next_exec;
      cmd_refused_o <= next_refused;
      cmd_opcode_o <= next_exec_op;
      cmd_addr_o <= next_exec_addr;
    end
  end

  assign pif.compl = prot[`FWG_COMPL_POS];
  assign pif.bp = prot[4:0];
  assign write_enable_latch_o = wr_latch;
  assign protect_complement_o = prot[`FWG_COMPL_POS];
  assign protect_bit4_granularity_o = prot[4];
  assign protect_bit3_top_bottom_o = prot[3];
  assign protect_bit2_o = prot[2];
  assign protect_bit1_o = prot[1];
  assign protect_bit0_o = prot[0];

  fwg_prot_decode u_decode
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pif(pif.decode)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_LATCH_SET: assert property
    (frame_end && op == `FWG_OP_WREN && aligned |=> wr_latch)
    else $error("Write enable did not set latch");
  AST_EXEC_NEEDS_LATCH: assert property
    (cmd_exec_o |-> $past(wr_latch))
    else $error("Command executed without latch");
  AST_EXTRA_BITS: assert property
    (frame_end && aligned && cnt != `FWG_CNT_OP &&
     (op == `FWG_OP_WREN || op == `FWG_OP_WRDI)
     |=> wr_latch == ($past(op) == `FWG_OP_WREN))
    else $error("Trailing bits disturbed latch command");
  AST_LATCH_KEEP: assert property
    (frame_end && !aligned &&
     (op == `FWG_OP_WREN || op == `FWG_OP_WRDI) |=> $stable(wr_latch))
    else $error("Unaligned frame changed latch");
  AST_LATCH_CLR: assert property
    (frame_end && op == `FWG_OP_WRDI && aligned |=> !wr_latch)
    else $error("Write disable did not clear latch");
  AST_PROT_SRC: assert property
    (!$stable(prot) |-> cmd_exec_o && cmd_opcode_o == `FWG_OP_WRSR)
    else $error("Protect bits changed outside status write");
  AST_PROT_BLOCK: assert property
    (frame_end && fwg_is_array(op) && pif.hit |=> !cmd_exec_o ##1 !cmd_exec_o)
    else $error("Protected region command executed");
  AST_ERASE_LATCH: assert property
    (cmd_exec_o && fwg_is_erase(cmd_opcode_o) |-> !wr_latch)
    else $error("Erase left latch set");
  AST_WP_LOCK: assert property
    (!wp_n_i |=> $stable(prot))
    else $error("Protect bits changed with pin low");

  COV_WEL_SET: cover property (frame_end && op == `FWG_OP_WREN && aligned);
  COV_EXEC: cover property (cmd_exec_o && fwg_is_erase(cmd_opcode_o));
  COV_REFUSED: cover property (cmd_refused_o && $past(pif.hit, 2));
  COV_WRSR: cover property (cmd_exec_o && cmd_opcode_o == `FWG_OP_WRSR);
endmodule

// File: verification/fwg_host_model.sv
// Host controller model that shifts command frames into the guard
`timescale 1ns/1ns
module fwg_host_model
(
  input wire logic clk_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic mosi_o
);
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end

  // Sends the top nbits MSB first; caller picks aligned or not
  task automatic send(input logic [39:0] bits, input int nbits);
    int i;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (i = 0; i < nbits; i++)
    begin
      @(posedge clk_i);
      mosi_o <= bits[39 - i];
      repeat (2) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // Idle data line carries no stale value
    mosi_o <= ~mosi_o;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// File: verification/flash_write_guard_protect_decode_tb_top.sv
// Self-checking bench of the flash write guard
`timescale 1ns/1ns
`include "fwg_regs.svh"
module flash_write_guard_protect_decode_tb_top;
  logic clk_i;
  logic sys_rst_i;
  logic wp_n;
  wire cs_n;
  wire sck;
  wire mosi;
  wire wr_latch;
  wire [5:0] prot;
  wire exec;
  wire refd;
  wire [7:0] opc;
  wire [23:0] addr;
  int failures = 0;
  int tests_run = 0;
  int n_exec = 0;
  int n_ref = 0;

  fwg_host_model u_fwg_host_model
  (
    .clk_i(clk_i),
    .cs_n_o(cs_n),
    .sck_o(sck),
    .mosi_o(mosi)
  );

  fwg_guard u_fwg_guard
  (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cs_n_i(cs_n),
    .sck_i(sck),
    .mosi_i(mosi),
    .wp_n_i(wp_n),
    .write_enable_latch_o(wr_latch),
    .protect_complement_o(prot[5]),
    .protect_bit4_granularity_o(prot[4]),
    .protect_bit3_top_bottom_o(prot[3]),
    .protect_bit2_o(prot[2]),
    .protect_bit1_o(prot[1]),
    .protect_bit0_o(prot[0]),
    .cmd_exec_o(exec),
    .cmd_refused_o(refd),
    .cmd_opcode_o(opc),
    .cmd_addr_o(addr)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Counts pulse cycles, so a long pulse shows as more than one
  always @(posedge clk_i)
  begin
    n_exec += (exec === 1'b1);
    n_ref += (refd === 1'b1);
  end

  // ****************
  // Helpers
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic frame(input logic [39:0] bits, input int nbits);
    n_exec = 0;
    n_ref = 0;
    u_fwg_host_model.send(bits, nbits);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    check({prot, wr_latch, exec, refd}, 0);
    check(opc, 0);
    check(addr, 0);
    $display("done reset");
  endtask

  task automatic t_latch();
    frame({`FWG_OP_WREN, 32'h0}, 16);
    check(wr_latch, 1);
    check(opc, `FWG_OP_WREN);
    frame({`FWG_OP_WRDI, 32'h0}, 12);
    check(wr_latch, 1);
    frame({`FWG_OP_WRDI, 32'h0}, 8);
    check(wr_latch, 0);
    frame({`FWG_OP_WREN, 32'h0}, 4);
    check(wr_latch, 0);
    frame({`FWG_OP_SE4K, 24'h01_0000, 8'h0}, 32);
    check(n_ref, 1);
    check(n_exec, 0);
    frame({`FWG_OP_SECE, 24'h00_1000, 8'h0}, 32);
    check(n_ref, 1);
    frame({`FWG_OP_WREN, 32'h0}, 8);
    frame({`FWG_OP_SE4K, 24'h01_0000, 8'h0}, 28);
    check(n_exec, 0);
    check(wr_latch, 1);
    $display("done latch");
  endtask

  task automatic t_status();
    wp_n <= 1'b0;
    frame({`FWG_OP_WRSR, 8'h5F, 24'h0}, 16);
    check(n_ref, 1);
    check(prot, 6'h00);
    wp_n <= 1'b1;
    frame({`FWG_OP_WRSR, 8'h5F, 24'h0}, 16);
    check(prot, 6'h3F);
    check(wr_latch, 0);
    frame({`FWG_OP_WRSR, 8'h00, 24'h0}, 16);
    check(n_ref, 1);
    check(prot, 6'h3F);
    $display("done status");
  endtask

  task automatic row(input logic [7:0] st, input logic [7:0] op,
    input logic [23:0] at, input int ok);
    int n;
    n = (op == `FWG_OP_CE_A || op == `FWG_OP_CE_B) ? 8 : 32;
    frame({`FWG_OP_WREN, 32'h0}, 8);
    frame({`FWG_OP_WRSR, st, 24'h0}, 16);
    check(prot, {st[6], st[4:0]});
    frame({`FWG_OP_WREN, 32'h0}, 8);
    frame({op, at, 8'h0}, n);
    check(n_exec, ok);
    check(n_ref, 1 - ok);
    check(wr_latch, 1 - ok);
    if (n == 32)
      check(addr, at);
  endtask

  task automatic t_table();
    row(8'h01, `FWG_OP_SE4K, 24'h07_0000, 0);
    row(8'h01, `FWG_OP_SE4K, 24'h06_F000, 1);
    row(8'h09, `FWG_OP_SE4K, 24'h00_F000, 0);
    row(8'h09, `FWG_OP_SE4K, 24'h01_0000, 1);
    row(8'h11, `FWG_OP_SE4K, 24'h07_F000, 0);
    row(8'h11, `FWG_OP_SE4K, 24'h07_E000, 1);
    row(8'h1A, `FWG_OP_SE4K, 24'h00_1000, 0);
    row(8'h1A, `FWG_OP_SE4K, 24'h00_2000, 1);
    row(8'h14, `FWG_OP_SE4K, 24'h07_8000, 0);
    row(8'h14, `FWG_OP_SE4K, 24'h07_7000, 1);
    row(8'h41, `FWG_OP_SE4K, 24'h06_F000, 0);
    row(8'h41, `FWG_OP_SE4K, 24'h07_0000, 1);
    row(8'h1F, `FWG_OP_PROG, 24'h07_E000, 0);
    row(8'h02, `FWG_OP_BE64, 24'h06_0000, 0);
    row(8'h02, `FWG_OP_BE32, 24'h05_8000, 1);
    row(8'h04, `FWG_OP_SECP, 24'h00_1000, 1);
    row(8'h00, `FWG_OP_CE_A, 24'h0, 1);
    row(8'h04, `FWG_OP_CE_B, 24'h0, 0);
    row(8'h44, `FWG_OP_CE_A, 24'h0, 1);
    row(8'h40, `FWG_OP_CE_B, 24'h0, 0);
    $display("done table");
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    wp_n = 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_latch();
    t_status();
    t_table();
    close_out();
  end

  initial
  begin
    repeat (60000) @(posedge clk_i);
    failures++;
    close_out();
  end
endmodule
